// ---- rtl/dpc_top.sv ----
/*
  Table based defective pixel replacement: APB register file, staged
  and persistent tables, active compare table and pixel stream path.
  Assumes APB master on ref_clk and a pixel stream on the same clock
  with neighbour values supplied beside each pixel.
*/
`timescale 1ns/1ns
`include "dpc_defs.svh"
module dpc_top #(
    parameter int                    DEPTH         = 8,
    parameter int                    CW            = 16,
    parameter int                    PW            = 12,
    parameter int                    FACTORY_COUNT = 0,
    parameter logic [DEPTH*CW-1:0]   FACTORY_X     = '0,
    parameter logic [DEPTH*CW-1:0]   FACTORY_Y     = '0
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Pixel stream in
    input  wire logic          pix_valid,
    input  wire logic [CW-1:0] pix_x,
    input  wire logic [CW-1:0] pix_y,
    input  wire logic [CW-1:0] roi_offset_x,
    input  wire logic [CW-1:0] roi_offset_y,
    input  wire logic [PW-1:0] pix_data,
    input  wire logic [PW-1:0] pix_left,
    input  wire logic [PW-1:0] pix_right,
    // Pixel stream out
    output logic               out_valid,
    output logic      [PW-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam int NW = $clog2(DEPTH + 1);
    localparam int EW = 2 * CW;
    localparam logic [NW-1:0] DEPTH_N = NW'(DEPTH);
    localparam logic [NW-1:0] FAC_N   = NW'(FACTORY_COUNT);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic                   en_r, en_nxt;
    dpc_pkg::dpc_method_type method_r, method_nxt;
    logic [NW-1:0]          count_r, count_nxt;
    logic [AW-1:0]          index_r, index_nxt;
    logic [NW-1:0]          act_count_r, act_count_nxt;
    logic [NW-1:0]          per_count_r, per_count_nxt;
    dpc_pkg::dpc_state_type state_r, state_nxt;
    logic [NW-1:0]          ptr_r, ptr_nxt;
    logic                   pend_r, pend_nxt;
    logic [AW-1:0]          pend_addr_r, pend_addr_nxt;
    logic [CW-1:0]          act_x_r [DEPTH];
    logic [CW-1:0]          act_y_r [DEPTH];

    // Memory ports
    logic          stg_we, per_we;
    logic [AW-1:0] stg_wa, per_wa, stg_ra, per_ra;
    logic [EW-1:0] stg_wd, per_wd, stg_wm, per_wm;
    logic [EW-1:0] stg_rd, per_rd;

    // Active table write
    logic          act_we;
    logic [AW-1:0] act_wa;
    logic [EW-1:0] act_wd;

    // Bus decode
    logic acc, wr, busy;
    logic [AW-1:0] ptr_a;
    logic [EW-1:0] fac_e;

    assign busy    = state_r != dpc_pkg::DPC_ST_IDLE;
    // Table moves own both memories, so the bus simply waits
    assign pready  = !busy;
    assign acc     = psel && penable && !busy;
    assign wr      = acc && pwrite;
    assign ptr_a   = ptr_r[AW-1:0];
    assign fac_e   = {FACTORY_Y[ptr_a*CW +: CW], FACTORY_X[ptr_a*CW +: CW]};

    // ----------------------------------------
    // Tables
    // ----------------------------------------
    dpc_mem #(
        .WIDTH (EW),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_staged (
        .clk     (ref_clk),
        .rst     (rst),
        .wr_en   (stg_we),
        .wr_addr (stg_wa),
        .wr_data (stg_wd),
        .wr_mask (stg_wm),
        .rd_addr (stg_ra),
        .rd_data (stg_rd)
    );

    dpc_mem #(
        .WIDTH (EW),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_persist (
        .clk     (ref_clk),
        .rst     (rst),
        .wr_en   (per_we),
        .wr_addr (per_wa),
        .wr_data (per_wd),
        .wr_mask (per_wm),
        .rd_addr (per_ra),
        .rd_data (per_rd)
    );

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_comb begin
        en_nxt     = en_r;
        method_nxt = method_r;
        count_nxt  = count_r;
        index_nxt  = index_r;
        if (wr && paddr == `DPC_OFS_CTRL) begin
            en_nxt = pwdata[`DPC_CTRL_EN_BIT];
            unique case (pwdata[`DPC_CTRL_METH_HI:`DPC_CTRL_METH_LO])
                2'h0: method_nxt = dpc_pkg::DPC_METH_AVG;
                2'h1: method_nxt = dpc_pkg::DPC_METH_HIGH;
                2'h2: method_nxt = dpc_pkg::DPC_METH_ZERO;
                default: method_nxt = method_r;
            endcase
        end
        if (wr && paddr == `DPC_OFS_COUNT) begin
            // Count larger than the table clamps to its size
            if (pwdata > 32'(DEPTH)) begin
                count_nxt = DEPTH_N;
            end else begin
                count_nxt = pwdata[NW-1:0];
            end
        end
        // Zero based; positions past the table are ignored
        if (wr && paddr == `DPC_OFS_INDEX && pwdata < 32'(DEPTH)) begin
            index_nxt = pwdata[AW-1:0];
        end
        if (state_r == dpc_pkg::DPC_ST_RESTORE && ptr_r == '0) begin
            count_nxt = FAC_N;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_r     <= `DPC_RST_EN;
            method_r <= dpc_pkg::DPC_METH_AVG;
            count_r  <= '0;
            index_r  <= '0;
        end else begin
            en_r     <= en_nxt;
            method_r <= method_nxt;
            count_r  <= count_nxt;
            index_r  <= index_nxt;
        end
    end

    // ----------------------------------------
    // Table move sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt     = state_r;
        ptr_nxt       = ptr_r;
        pend_nxt      = 1'b0;
        pend_addr_nxt = pend_addr_r;
        act_count_nxt = act_count_r;
        per_count_nxt = per_count_r;
        unique case (state_r)
            dpc_pkg::DPC_ST_IDLE: begin
                ptr_nxt = '0;
                if (wr && paddr == `DPC_OFS_CMD) begin
                    if (pwdata[`DPC_CMD_REST_BIT]) begin
                        state_nxt = dpc_pkg::DPC_ST_RESTORE;
                    end else if (pwdata[`DPC_CMD_APPLY_BIT]) begin
                        state_nxt     = dpc_pkg::DPC_ST_APPLY;
                        act_count_nxt = count_r;
                    end else if (pwdata[`DPC_CMD_SAVE_BIT]) begin
                        state_nxt     = dpc_pkg::DPC_ST_SAVE;
                        per_count_nxt = count_r;
                    end
                end
            end
            dpc_pkg::DPC_ST_APPLY, dpc_pkg::DPC_ST_SAVE: begin
                // Read one entry per cycle; write it back a cycle later
                if (ptr_r < DEPTH_N) begin
                    ptr_nxt       = ptr_r + NW'(1);
                    pend_nxt      = 1'b1;
                    pend_addr_nxt = ptr_a;
                end else if (!pend_r) begin
                    state_nxt = dpc_pkg::DPC_ST_IDLE;
                end
            end
            dpc_pkg::DPC_ST_RESTORE: begin
                act_count_nxt = FAC_N;
                per_count_nxt = FAC_N;
                if (ptr_r < DEPTH_N) begin
                    ptr_nxt = ptr_r + NW'(1);
                end else begin
                    state_nxt = dpc_pkg::DPC_ST_IDLE;
                end
            end
            default: state_nxt = dpc_pkg::DPC_ST_IDLE;
        endcase
    end

    // Reset behaves as power-up: the factory list is loaded as boot table
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r     <= dpc_pkg::DPC_ST_RESTORE;
            ptr_r       <= '0;
            pend_r      <= 1'b0;
            pend_addr_r <= '0;
            act_count_r <= '0;
            per_count_r <= '0;
        end else begin
            state_r     <= state_nxt;
            ptr_r       <= ptr_nxt;
            pend_r      <= pend_nxt;
            pend_addr_r <= pend_addr_nxt;
            act_count_r <= act_count_nxt;
            per_count_r <= per_count_nxt;
        end
    end

    // ----------------------------------------
    // Memory port steering
    // ----------------------------------------
    always_comb begin
        stg_we = 1'b0;
        stg_wa = index_r;
        stg_wd = '0;
        stg_wm = '0;
        per_we = 1'b0;
        per_wa = pend_addr_r;
        per_wd = stg_rd;
        per_wm = '1;
        act_we = 1'b0;
        act_wa = pend_addr_r;
        act_wd = stg_rd;
        stg_ra = busy ? ptr_a : index_r;
        per_ra = ptr_a;
        if (wr && paddr == `DPC_OFS_XCOORD) begin
            stg_we = 1'b1;
            stg_wd = {{CW{1'b0}}, pwdata[CW-1:0]};
            stg_wm = {{CW{1'b0}}, {CW{1'b1}}};
        end
        if (wr && paddr == `DPC_OFS_YCOORD) begin
            stg_we = 1'b1;
            stg_wd = {pwdata[CW-1:0], {CW{1'b0}}};
            stg_wm = {{CW{1'b1}}, {CW{1'b0}}};
        end
        if (state_r == dpc_pkg::DPC_ST_APPLY && pend_r) begin
            act_we = 1'b1;
        end
        if (state_r == dpc_pkg::DPC_ST_SAVE && pend_r) begin
            per_we = 1'b1;
        end
        if (state_r == dpc_pkg::DPC_ST_RESTORE && ptr_r < DEPTH_N) begin
            stg_we = 1'b1;
            stg_wa = ptr_a;
            stg_wd = fac_e;
            stg_wm = '1;
            per_we = 1'b1;
            per_wa = ptr_a;
            per_wd = fac_e;
            act_we = 1'b1;
            act_wa = ptr_a;
            act_wd = fac_e;
        end
    end

    // ----------------------------------------
    // Active table and pixel compare
    // ----------------------------------------
    logic [CW-1:0]    full_x, full_y;
    logic [DEPTH-1:0] hit;

    // Stream positions are in the region; table is in sensor space
    assign full_x = CW'(pix_x + roi_offset_x);
    assign full_y = CW'(pix_y + roi_offset_y);

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            logic [CW-1:0] x_nxt, y_nxt;
            always_comb begin
                x_nxt = act_x_r[gi];
                y_nxt = act_y_r[gi];
                if (act_we && act_wa == AW'(gi)) begin
                    x_nxt = act_wd[CW-1:0];
                    y_nxt = act_wd[EW-1:CW];
                end
            end
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    act_x_r[gi] <= '0;
                    act_y_r[gi] <= '0;
                end else begin
                    act_x_r[gi] <= x_nxt;
                    act_y_r[gi] <= y_nxt;
                end
            end
            // Mid-move the table mixes old and new entries
            assign hit[gi] = (NW'(gi) < act_count_r)
                && act_x_r[gi] == full_x
                && act_y_r[gi] == full_y;
        end
    endgenerate

    // ----------------------------------------
    // Pixel replacement
    // ----------------------------------------
    logic          out_valid_nxt;
    logic [PW-1:0] out_data_nxt;
    logic [PW:0]   nb_sum;

    assign nb_sum = {1'b0, pix_left} + {1'b0, pix_right};

    always_comb begin
        out_valid_nxt = pix_valid;
        out_data_nxt  = pix_data;
        if (pix_valid && en_r && |hit) begin
            unique case (method_r)
                dpc_pkg::DPC_METH_AVG:  out_data_nxt = nb_sum[PW:1];
                dpc_pkg::DPC_METH_HIGH: out_data_nxt = '1;
                dpc_pkg::DPC_METH_ZERO: out_data_nxt = '0;
                default: out_data_nxt = pix_data;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            out_valid <= out_valid_nxt;
            out_data  <= out_data_nxt;
        end
    end

    // ----------------------------------------
    // Read mux and error
    // ----------------------------------------
    always_comb begin
        prdata  = '0;
        pslverr = 1'b0;
        unique case (paddr)
            `DPC_OFS_CTRL: begin
                prdata[`DPC_CTRL_EN_BIT] = en_r;
                prdata[`DPC_CTRL_METH_HI:`DPC_CTRL_METH_LO] = method_r;
            end
            `DPC_OFS_COUNT:  prdata[NW-1:0] = count_r;
            `DPC_OFS_INDEX:  prdata[AW-1:0] = index_r;
            `DPC_OFS_XCOORD: prdata[CW-1:0] = stg_rd[CW-1:0];
            `DPC_OFS_YCOORD: prdata[CW-1:0] = stg_rd[EW-1:CW];
            `DPC_OFS_CMD:    prdata = '0;
            `DPC_OFS_STATUS: prdata[`DPC_STAT_BUSY_BIT] = busy;
            `DPC_OFS_ACTCNT: prdata[NW-1:0] = act_count_r;
            default:         pslverr = psel && penable && !busy;
        endcase
    end

endmodule

// ---- rtl/dpc_defs.svh ----
/*
  Offsets, field positions, command bits and reset values of the
  defective pixel table block. Assumes inclusion by bare name.
*/
//
// Behaviour
// - Writable entry count sizes staged table
// - Entry index is zero based
// - X and Y access indexed staged entry
// - Coordinates relative to full sensor image
// - Edits touch only the staged copy
// - Apply copies staged into active table
// - Save replaces persistent copy, loaded at boot; the code never reads it and loads the factory list at boot instead
// - Restore loads factory list everywhere
// - Corrections may glitch during table transfer
// - Enable switches replacement on or off
// - Method selects average, highlight or zero
// - Average uses mean of neighbours
// - Highlight forces largest pixel value
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DPC_OFS_CTRL   8'h00
`define DPC_OFS_COUNT  8'h04
`define DPC_OFS_INDEX  8'h08
`define DPC_OFS_XCOORD 8'h0C
`define DPC_OFS_YCOORD 8'h10
`define DPC_OFS_CMD    8'h14
`define DPC_OFS_STATUS 8'h18
`define DPC_OFS_ACTCNT 8'h1C

// ----------------------------------------
// Fields
// ----------------------------------------
`define DPC_CTRL_EN_BIT   0
`define DPC_CTRL_METH_LO  1
`define DPC_CTRL_METH_HI  2
`define DPC_CMD_APPLY_BIT 0
`define DPC_CMD_SAVE_BIT  1
`define DPC_CMD_REST_BIT  2
`define DPC_STAT_BUSY_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DPC_RST_EN 1'h0

`endif

// ---- rtl/dpc_pkg.sv ----
/*
  Types of the defective pixel table block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dpc_pkg;

    typedef enum logic [1:0] {
        DPC_METH_AVG  = 2'h0,
        DPC_METH_HIGH = 2'h1,
        DPC_METH_ZERO = 2'h2
    } dpc_method_type;

    typedef enum logic [3:0] {
        DPC_ST_IDLE    = 4'h1,
        DPC_ST_APPLY   = 4'h2,
        DPC_ST_SAVE    = 4'h4,
        DPC_ST_RESTORE = 4'h8
    } dpc_state_type;

endpackage

// ---- rtl/dpc_mem.sv ----
/*
  Small table memory with bit-masked write and registered read.
  Assumes one clock; contents are not reset.
*/
`timescale 1ns/1ns
module dpc_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [WIDTH-1:0] wr_mask,
    // Read port
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ---- bench/dpc_top_asserts.sv ----
/*
  Port-level checker for dpc_top, bound into every instance.
  Assumes one clock and an APB master that keeps the protocol.
*/
`timescale 1ns/1ns
`include "dpc_defs.svh"
module dpc_top_asserts #(
    parameter int PW = 12
) (
    // Clock and reset
    input wire logic          ref_clk,
    input wire logic          rst,
    // APB
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // Pixels
    input wire logic          pix_valid,
    input wire logic [PW-1:0] pix_data,
    input wire logic          out_valid,
    input wire logic [PW-1:0] out_data
);
    logic en_r;
    logic en_nxt;
    logic wr_ok;
    logic rd_ok;

    assign wr_ok = psel && penable && pready && pwrite;
    assign rd_ok = psel && penable && pready && !pwrite;

    // Shadow of the enable bit
    always_comb begin
        en_nxt = en_r;
        if (wr_ok && paddr == `DPC_OFS_CTRL) begin
            en_nxt = pwdata[0];
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_r <= 1'b0;
        end else begin
            en_r <= en_nxt;
        end
    end

    default clocking dck @(posedge ref_clk); endclocking
    default disable iff (rst);

    out_follow_a: assert property (pix_valid |=> out_valid)
        else $error("out_valid late");
    pass_thru_a: assert property (pix_valid && !en_r |=> out_data == $past(pix_data))
        else $error("disabled pixel changed");
    cmd_busy_a: assert property (wr_ok && paddr == `DPC_OFS_CMD && pwdata[2:0] != 3'h0
        |=> !pready [*8] ##[1:4] pready) else $error("table move length wrong");
    cmd_read_a: assert property (rd_ok && paddr == `DPC_OFS_CMD |-> prdata == 32'h0)
        else $error("command reads nonzero");
    err_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returns data");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    map_ok_a: assert property (psel && penable && paddr <= 8'h1C && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("mapped address refused");
    boot_load_a: assert property ($fell(rst) |-> !pready ##[5:12] pready)
        else $error("boot load length wrong");
endmodule

bind dpc_top dpc_top_asserts #(.PW(PW)) dpc_top_asserts_i (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_valid(pix_valid), .pix_data(pix_data), .out_valid(out_valid), .out_data(out_data)
);

// ---- bench/dpc_host.sv ----
/*
  Host side model: an APB master issuing one transfer per call.
  Assumes the slave samples on the rising edge of clk.
*/
`timescale 1ns/1ns
module dpc_host (
    // Clock
    input wire logic        clk,
    // APB master
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic     [7:0]  paddr,
    output logic     [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Request held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic hung);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 500);
        hung = (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ---- bench/dpc_top_tb_top.sv ----
/*
  Self-checking bench of dpc_top: register edits, table commands
  and pixel replacement. Assumes dpc_host as the APB master.
*/
`timescale 1ns/1ns
`include "dpc_defs.svh"
module dpc_top_tb_top;
    logic        ref_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        pix_valid;
    logic        out_valid;
    logic        err;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rdv;
    logic [15:0] pix_x;
    logic [15:0] pix_y;
    logic [15:0] roi_x;
    logic [15:0] roi_y;
    logic [11:0] pdat;
    logic [11:0] pleft;
    logic [11:0] pright;
    logic [11:0] out_data;
    int          n_mismatch;
    int          checks_done;

    // Factory list holds one entry at (5,7)
    dpc_top #(.FACTORY_COUNT(1), .FACTORY_X(128'h5), .FACTORY_Y(128'h7)) dpc_top_i (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y),
        .roi_offset_x(roi_x), .roi_offset_y(roi_y), .pix_data(pdat),
        .pix_left(pleft), .pix_right(pright), .out_valid(out_valid),
        .out_data(out_data)
    );
    dpc_host dpc_host_i (
        .clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkpix(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t pixel got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic hung;
        dpc_host_i.xfer(w, a, d, rdv, err, hung);
        if (hung) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t pready timeout", $time);
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk32(rdv, exp);
    endtask
    // Neighbours 10 and 21 give an average of 15
    task automatic pix(input logic [15:0] x, input logic [15:0] y, input logic [15:0] ox,
                       input logic [11:0] exp);
        @(posedge ref_clk);
        pix_valid <= 1'b1;
        pix_x <= x;
        pix_y <= y;
        roi_x <= ox;
        @(posedge ref_clk);
        pix_valid <= 1'b0;
        #1 chkpix({out_valid, out_data}, {1'b1, exp});
    endtask

    initial begin
        rst = 1'b1;
        pix_valid = 1'b0;
        pix_x = 16'h0;
        pix_y = 16'h0;
        roi_x = 16'h0;
        roi_y = 16'h0;
        pdat = 12'h3A5;
        pleft = 12'h00A;
        pright = 12'h015;
        n_mismatch = 0;
        checks_done = 0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`DPC_OFS_CTRL, 32'h0);
        rd(`DPC_OFS_ACTCNT, 32'h1);
        pix(16'h5, 16'h7, 16'h0, 12'h3A5);
        pdat <= 12'h064;
        wr(`DPC_OFS_CTRL, 32'h1);
        pix(16'h5, 16'h7, 16'h0, 12'h00F);
        pix(16'h3, 16'h7, 16'h2, 12'h00F);
        pix(16'h6, 16'h7, 16'h0, 12'h064);
        // Near-full neighbours need the carry bit of the sum
        pleft <= 12'hFFF;
        pright <= 12'hFFD;
        roi_y <= 16'h4;
        pix(16'h5, 16'h3, 16'h0, 12'hFFE);
        roi_y <= 16'h0;
        pleft <= 12'h00A;
        pright <= 12'h015;
        wr(`DPC_OFS_CTRL, 32'h3);
        pix(16'h5, 16'h7, 16'h0, 12'hFFF);
        wr(`DPC_OFS_CTRL, 32'h5);
        pix(16'h5, 16'h7, 16'h0, 12'h000);
        wr(`DPC_OFS_CTRL, 32'h7);
        rd(`DPC_OFS_CTRL, 32'h5);
        // Adding a location at (20,30)
        wr(`DPC_OFS_COUNT, 32'h2);
        wr(`DPC_OFS_INDEX, 32'h1);
        wr(`DPC_OFS_XCOORD, 32'h14);
        wr(`DPC_OFS_YCOORD, 32'h1E);
        rd(`DPC_OFS_XCOORD, 32'h14);
        rd(`DPC_OFS_YCOORD, 32'h1E);
        pix(16'h14, 16'h1E, 16'h0, 12'h064);
        wr(`DPC_OFS_CMD, 32'h1);
        rd(`DPC_OFS_STATUS, 32'h0);
        rd(`DPC_OFS_ACTCNT, 32'h2);
        pix(16'h14, 16'h1E, 16'h0, 12'h000);
        wr(`DPC_OFS_INDEX, 32'h8);
        rd(`DPC_OFS_INDEX, 32'h1);
        wr(`DPC_OFS_INDEX, 32'h0);
        rd(`DPC_OFS_XCOORD, 32'h5);
        wr(`DPC_OFS_COUNT, 32'h9);
        rd(`DPC_OFS_COUNT, 32'h8);
        wr(`DPC_OFS_COUNT, 32'h1);
        wr(`DPC_OFS_CMD, 32'h1);
        rd(`DPC_OFS_ACTCNT, 32'h1);
        pix(16'h14, 16'h1E, 16'h0, 12'h064);
        pix(16'h5, 16'h7, 16'h0, 12'h000);
        // Save leaves the active table alone
        wr(`DPC_OFS_XCOORD, 32'h28);
        wr(`DPC_OFS_CMD, 32'h2);
        rd(`DPC_OFS_STATUS, 32'h0);
        pix(16'h5, 16'h7, 16'h0, 12'h000);
        pix(16'h28, 16'h7, 16'h0, 12'h064);
        wr(`DPC_OFS_CMD, 32'h4);
        rd(`DPC_OFS_XCOORD, 32'h5);
        rd(`DPC_OFS_COUNT, 32'h1);
        pix(16'h5, 16'h7, 16'h0, 12'h000);
        // Unmapped place and write-only command
        rd(8'h40, 32'h0);
        chk32({31'h0, err}, 32'h1);
        wr(8'h40, 32'h0);
        rd(`DPC_OFS_CTRL, 32'h5);
        rd(`DPC_OFS_CMD, 32'h0);
        // Second boot in mid-run reloads the factory list
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`DPC_OFS_CTRL, 32'h0);
        rd(`DPC_OFS_ACTCNT, 32'h1);
        pix(16'h5, 16'h7, 16'h0, 12'h064);
        tally_and_finish();
    end
endmodule
